// >>> core/mmcs_channel_regs.sv
// Control, status and finished-descriptor tally registers of two DMA channels.
`timescale 1ns/1ns
module mmcs_channel_regs (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [13:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Engine events, index 0 card-to-host, index 1 host-to-card (one-cycle pulses).
  input wire logic [1:0] DESC_DONE,
  input wire logic [1:0] DESC_DONE_MARKER,
  input wire logic [1:0] DESC_DONE_STOP,
  input wire logic [1:0] DESC_BAD_LENGTH,
  input wire logic [1:0] DESC_BAD_SIGNATURE,
  input wire logic [1:0] DESC_MISALIGNED,
  input wire logic [9:0] DESC_ERR_CAUSE,
  input wire logic [9:0] READ_ERR_CAUSE,
  // Controls to each engine (registered).
  output logic [1:0] ENGINE_RUN,
  output logic [1:0] ADDR_HOLD,
  output logic [1:0] STREAM_METADATA_WRITEBACK_OFF,
  output logic [1:0] TALLY_WRITEBACK,
  output logic [63:0] TALLY_VALUE,
  output logic [1:0] ENGINE_BUSY
);

  // Per-channel state.
  typedef struct packed {
    logic [31:0] ctl;
    logic [31:0] st;
    logic [31:0] cnt;
    logic run_q;
    mmcs_pkg::mmcs_eng_t eng;
    logic wb;
  } mmcs_chan_t;

  // Whole module state: two channels plus the bus answer.
  typedef struct packed {
    mmcs_chan_t [1:0] ch;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } mmcs_state_t;

  mmcs_state_t s_r; // Registered state.
  mmcs_state_t s_nxt; // Next state.

  //============================================================================
  // Address decode.
  //============================================================================
  logic [1:0] hit; // One-hot channel select.
  logic [8:0] off; // Offset within window.
  logic acc; // Access phase, answered on the next cycle.

  // Decode the channel window from the byte address.
  always_comb begin
    hit[0] = (PADDR >= mmcs_pkg::CARD_TO_HOST_BASE) &&
      (PADDR < mmcs_pkg::CARD_TO_HOST_BASE + mmcs_pkg::CHAN_SPAN);
    hit[1] = (PADDR >= mmcs_pkg::HOST_TO_CARD_BASE) &&
      (PADDR < mmcs_pkg::HOST_TO_CARD_BASE + mmcs_pkg::CHAN_SPAN);
    off = PADDR[8:0];
    acc = PSEL && PENABLE;
  end

  //============================================================================
  // Next-state logic.
  //============================================================================
  // Each channel is handled in one loop pass; the bus answer follows after.
  always_comb begin
    logic [31:0] wr_st;
    logic [31:0] ev;
    logic busy;
    logic rise;
    logic mapped;
    wr_st = '0;
    ev = '0;
    busy = 1'b0;
    rise = 1'b0;
    mapped = 1'b0;
    s_nxt = s_r;
    s_nxt.ready = 1'b0;
    s_nxt.slverr = 1'b0;
    s_nxt.rdata = '0;
    for (int c = 0; c < 2; c++) begin
      // Control writes through the plain, set and clear aliases.
      if (acc && PWRITE && hit[c] && !s_r.ready) begin
        if (off == mmcs_pkg::OFF_CONTROL) begin
          s_nxt.ch[c].ctl = PWDATA & mmcs_pkg::CTL_MASK;
        end else if (off == mmcs_pkg::OFF_CONTROL_SET) begin
          s_nxt.ch[c].ctl = s_r.ch[c].ctl | (PWDATA & mmcs_pkg::CTL_MASK);
        end else if (off == mmcs_pkg::OFF_CONTROL_CLR) begin
          s_nxt.ch[c].ctl = s_r.ch[c].ctl & ~PWDATA;
        end
      end
      rise = s_nxt.ch[c].ctl[mmcs_pkg::CTL_RUN] && !s_r.ch[c].ctl[mmcs_pkg::CTL_RUN];

      // Engine tracking: run starts it, dropping run lets the current
      // descriptor finish, an armed error halts it at once.
      ev = '0;
      ev[mmcs_pkg::ST_DESC_STOPPED] = DESC_DONE_STOP[c] && s_r.ch[c].ctl[mmcs_pkg::CTL_IE_DESC_STOPPED];
      ev[mmcs_pkg::ST_DESC_COMPLETED] = DESC_DONE_MARKER[c] &&
        s_r.ch[c].ctl[mmcs_pkg::CTL_IE_DESC_COMPLETED];
      ev[mmcs_pkg::ST_ALIGN] = DESC_MISALIGNED[c] && s_r.ch[c].ctl[mmcs_pkg::CTL_IE_ALIGN];
      ev[mmcs_pkg::ST_MAGIC] = DESC_BAD_SIGNATURE[c] && s_r.ch[c].ctl[mmcs_pkg::CTL_IE_MAGIC];
      ev[mmcs_pkg::ST_LENGTH] = DESC_BAD_LENGTH[c] && s_r.ch[c].ctl[mmcs_pkg::CTL_IE_LENGTH];
      if (s_r.ch[c].ctl[23:19] == mmcs_pkg::ERR_ARM) begin
        ev[23:19] = DESC_ERR_CAUSE[c*5 +: 5];
      end
      if (s_r.ch[c].ctl[13:9] == mmcs_pkg::ERR_ARM) begin
        ev[13:9] = READ_ERR_CAUSE[c*5 +: 5] & mmcs_pkg::RD_ERR_VALID;
      end

      case (s_r.ch[c].eng)
        mmcs_pkg::MMCS_IDLE: begin
          if (s_r.ch[c].ctl[mmcs_pkg::CTL_RUN]) begin
            s_nxt.ch[c].eng = mmcs_pkg::MMCS_RUN;
          end
        end
        mmcs_pkg::MMCS_RUN: begin
          if ((|ev[23:19]) || (|ev[13:9]) || DESC_BAD_SIGNATURE[c]) begin
            s_nxt.ch[c].eng = mmcs_pkg::MMCS_IDLE;
            s_nxt.ch[c].ctl[mmcs_pkg::CTL_RUN] = 1'b0;
          end else if (!s_r.ch[c].ctl[mmcs_pkg::CTL_RUN]) begin
            s_nxt.ch[c].eng = mmcs_pkg::MMCS_DRAIN;
          end
        end
        mmcs_pkg::MMCS_DRAIN: begin
          // Waits for the descriptor in flight to end; DESC_DONE closes it.
          if (DESC_DONE[c] || (|ev[23:19]) || (|ev[13:9]) || DESC_BAD_SIGNATURE[c]) begin
            s_nxt.ch[c].eng = mmcs_pkg::MMCS_IDLE;
            ev[mmcs_pkg::ST_IDLE] = s_r.ch[c].ctl[mmcs_pkg::CTL_IE_IDLE];
          end
        end
        default: begin
          s_nxt.ch[c].eng = mmcs_pkg::MMCS_IDLE;
        end
      endcase
      busy = (s_r.ch[c].eng != mmcs_pkg::MMCS_IDLE);
      // The run output is kept in its own flop, so the port carries no decode logic.
      s_nxt.ch[c].run_q = (s_nxt.ch[c].eng == mmcs_pkg::MMCS_RUN);

      // Status: write-one-clear at 0x40, read-clear at 0x44, run rise clears;
      // a new event in the same cycle always survives the clear.
      wr_st = s_r.ch[c].st;
      if (acc && PWRITE && hit[c] && !s_r.ready && off == mmcs_pkg::OFF_STATUS) begin
        wr_st = wr_st & ~PWDATA;
      end
      if (acc && !PWRITE && hit[c] && !s_r.ready && off == mmcs_pkg::OFF_STATUS_RC) begin
        wr_st = '0;
      end
      if (rise) begin
        wr_st = '0;
      end
      s_nxt.ch[c].st = ((wr_st | ev) & mmcs_pkg::ST_STICKY_MASK) |
        {31'h0, s_nxt.ch[c].eng != mmcs_pkg::MMCS_IDLE};

      // Tally of finished descriptors, zeroed when run rises.
      if (rise) begin
        s_nxt.ch[c].cnt = mmcs_pkg::COUNT_RESET;
      end else if (DESC_DONE[c] && busy) begin
        s_nxt.ch[c].cnt = s_r.ch[c].cnt + 32'h1;
      end
      s_nxt.ch[c].wb = DESC_DONE_MARKER[c] && busy && s_r.ch[c].ctl[mmcs_pkg::CTL_POLL_WB];

      // Read data for this channel.
      if (acc && !PWRITE && hit[c] && !s_r.ready) begin
        case (off)
          mmcs_pkg::OFF_CONTROL: s_nxt.rdata = s_r.ch[c].ctl;
          mmcs_pkg::OFF_STATUS: s_nxt.rdata = s_r.ch[c].st;
          mmcs_pkg::OFF_STATUS_RC: s_nxt.rdata = s_r.ch[c].st;
          mmcs_pkg::OFF_COUNT: s_nxt.rdata = s_r.ch[c].cnt;
          default: s_nxt.rdata = '0;
        endcase
      end
    end

    // Bus answer: one wait state, error on any access, read or write, to an unmapped offset.
    mapped = (hit != 2'b00) && (off == mmcs_pkg::OFF_CONTROL || off == mmcs_pkg::OFF_CONTROL_SET ||
      off == mmcs_pkg::OFF_CONTROL_CLR || off == mmcs_pkg::OFF_STATUS ||
      off == mmcs_pkg::OFF_STATUS_RC || off == mmcs_pkg::OFF_COUNT);
    if (acc && !s_r.ready) begin
      s_nxt.ready = 1'b1;
      s_nxt.slverr = !mapped;
    end
  end

  //============================================================================
  // State register.
  //============================================================================
  // All state resets to zero, which matches every documented reset value.
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  //============================================================================
  // Outputs, all taken straight from the state register.
  //============================================================================
  always_comb begin
    PRDATA = s_r.rdata;
    PREADY = s_r.ready;
    PSLVERR = s_r.slverr;
    for (int c = 0; c < 2; c++) begin
      ENGINE_RUN[c] = s_r.ch[c].run_q;
      ADDR_HOLD[c] = s_r.ch[c].ctl[mmcs_pkg::CTL_NON_INC];
      STREAM_METADATA_WRITEBACK_OFF[c] = s_r.ch[c].ctl[mmcs_pkg::CTL_STREAM_WB_OFF];
      TALLY_WRITEBACK[c] = s_r.ch[c].wb;
      TALLY_VALUE[c*32 +: 32] = s_r.ch[c].cnt;
      ENGINE_BUSY[c] = s_r.ch[c].st[mmcs_pkg::ST_BUSY];
    end
  end

endmodule

// >>> dv/mmcs_channel_regs_checker.sv
// Assertion checker for the channel register block.
`timescale 1ns/1ns
module mmcs_channel_regs_checker (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [1:0] DESC_DONE,
  input wire logic [1:0] DESC_DONE_MARKER,
  input wire logic [1:0] ENGINE_RUN,
  input wire logic [1:0] ADDR_HOLD,
  input wire logic [1:0] TALLY_WRITEBACK,
  input wire logic [63:0] TALLY_VALUE
);
  //======
  // Bus timing.
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // An access phase not yet answered.
  sequence s_wait;
    PSEL && PENABLE && !PREADY;
  endsequence
  // The answer stands for exactly one cycle.
  sequence s_answer;
    PREADY ##1 !PREADY;
  endsequence
  a_one_wait_state: assert property (s_wait |=> s_answer)
    else $error("access answer late or long");
  a_err_with_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error without answer or with data");
  a_idle_data_zero: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside answer");
  //======
  // Engine side.
  a_tally_step: assert property (!$stable(TALLY_VALUE[31:0]) |-> TALLY_VALUE[31:0] == 32'h0 ||
    (TALLY_VALUE[31:0] == $past(TALLY_VALUE[31:0]) + 32'h1 && ($past(DESC_DONE[0]) || $past(DESC_DONE[0], 2))))
    else $error("tally moved without a finish");
  a_wb_card: assert property (TALLY_WRITEBACK[0] |-> $past(DESC_DONE_MARKER[0]))
    else $error("writeback without marker");
  a_wb_host: assert property (TALLY_WRITEBACK[1] |-> $past(DESC_DONE_MARKER[1]))
    else $error("writeback without marker");
  // A card-to-host run start must follow a bus answer, read or write, within three cycles.
  a_run_after_write: assert property ($rose(ENGINE_RUN[0]) |->
    $past(PREADY) || $past(PREADY, 2) || $past(PREADY, 3))
    else $error("engine started without a write");
  a_hold_after_write: assert property (!$stable(ADDR_HOLD) |->
    PREADY || $past(PREADY) || $past(PREADY, 2))
    else $error("address hold moved without a write");
endmodule
bind mmcs_channel_regs mmcs_channel_regs_checker mmcs_channel_regs_checker_i (.REF_CLK(REF_CLK),
  .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .DESC_DONE(DESC_DONE), .DESC_DONE_MARKER(DESC_DONE_MARKER), .ENGINE_RUN(ENGINE_RUN),
  .ADDR_HOLD(ADDR_HOLD), .TALLY_WRITEBACK(TALLY_WRITEBACK), .TALLY_VALUE(TALLY_VALUE));

// >>> dv/mmcs_channel_regs_tb.sv
// Self-checking testbench for the channel register block.
`timescale 1ns/1ns
module mmcs_channel_regs_tb;
  logic REF_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [13:0] PADDR = 14'h0;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [1:0] ENGINE_RUN;
  logic [1:0] ADDR_HOLD;
  logic [1:0] wb_off;
  logic [1:0] busy;
  logic [1:0] twb;
  logic [63:0] tally;
  // Counts card-to-host tally writeback pulses.
  int wb_seen = 0;
  // All engine event pulses packed into one word, split per port below.
  logic [31:0] ev = 32'h0;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int n_compared = 0;
  localparam logic [13:0] C0 = mmcs_pkg::CARD_TO_HOST_BASE;
  localparam logic [13:0] C1 = mmcs_pkg::HOST_TO_CARD_BASE;
  always #5 REF_CLK = ~REF_CLK;
  mmcs_channel_regs mmcs_channel_regs_i (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DESC_DONE(ev[1:0]), .DESC_DONE_MARKER(ev[3:2]), .DESC_DONE_STOP(ev[5:4]), .DESC_BAD_LENGTH(ev[7:6]),
    .DESC_BAD_SIGNATURE(ev[9:8]), .DESC_MISALIGNED(ev[11:10]), .DESC_ERR_CAUSE(ev[21:12]),
    .READ_ERR_CAUSE(ev[31:22]), .ENGINE_RUN(ENGINE_RUN), .ADDR_HOLD(ADDR_HOLD),
    .STREAM_METADATA_WRITEBACK_OFF(wb_off), .TALLY_WRITEBACK(twb), .TALLY_VALUE(tally), .ENGINE_BUSY(busy));
  // Writeback strobes stand one cycle, so they are tallied at each edge.
  always @(posedge REF_CLK) begin
    if (twb[0] === 1'b1) begin
      wb_seen++;
    end
  end
  //======
  // Compare a masked value and count it.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request holds until PREADY is seen at an edge, or for at most 40 edges.
  task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 40);
    if (n == 40) err_count++;
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task rdc(input logic [13:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask
  // Raise event inputs for one cycle, then let the flags land.
  task pulse(input logic [31:0] v);
    @(posedge REF_CLK);
    ev <= v;
    @(posedge REF_CLK);
    ev <= 32'h0;
    @(posedge REF_CLK);
  endtask
  task final_report();
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // A hang ends the run as a failure.
  initial begin
    repeat (5000) @(posedge REF_CLK);
    err_count++;
    final_report();
  end
  //======
  // Main sequence.
  initial begin
    repeat (6) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      rdc(C0 + 14'(i) * mmcs_pkg::CHAN_SPAN + 14'h4, 32'h0, '1);
      rdc(C0 + 14'(i) * mmcs_pkg::CHAN_SPAN + 14'h40, 32'h0, '1);
      rdc(C0 + 14'(i) * mmcs_pkg::CHAN_SPAN + 14'h48, 32'h0, '1);
    end
    apb(1'b1, C1 + 14'h8, 32'h06000000);
    rdc(C1 + 14'h4, 32'h06000000, '1);
    chk({30'h0, ADDR_HOLD}, 32'h2);
    apb(1'b1, C1 + 14'h8, 32'h08000000);
    rdc(C1 + 14'h4, 32'h0e000000, '1);
    chk({30'h0, wb_off}, 32'h2);
    apb(1'b1, C1 + 14'hc, 32'h02000000);
    rdc(C1 + 14'h4, 32'h0c000000, '1);
    chk({30'h0, ADDR_HOLD}, 32'h0);
    // Card-to-host runs with every enable and both error fields armed.
    apb(1'b1, C0 + 14'h4, 32'h04f83e7f);
    repeat (3) @(posedge REF_CLK);
    chk({31'h0, ENGINE_RUN[0]}, 32'h1);
    chk({31'h0, busy[0]}, 32'h1);
    pulse(32'h5);
    pulse(32'h5);
    rdc(C0 + 14'h48, 32'h2, '1);
    chk(tally[31:0], 32'h2);
    chk(32'(wb_seen), 32'h2);
    rdc(C0 + 14'h40, 32'h5, '1);
    pulse(32'h451);
    rdc(C0 + 14'h44, 32'h2f, '1);
    rdc(C0 + 14'h40, 32'h1, '1);
    pulse(32'h5);
    apb(1'b1, C0 + 14'h40, 32'h4);
    rdc(C0 + 14'h40, 32'h1, '1);
    rdc(C0 + 14'h48, 32'h4, '1);
    pulse(32'h100);
    rdc(C0 + 14'h40, 32'h10, 32'h10);
    rdc(C0 + 14'h4, 32'h04f83e7e, '1);
    apb(1'b1, C0 + 14'h8, 32'h1);
    rdc(C0 + 14'h48, 32'h0, '1);
    rdc(C0 + 14'h40, 32'h0, 32'h00f83e7e);
    pulse(32'h00400000);
    rdc(C0 + 14'h40, 32'h200, 32'h00f83e00);
    rdc(C0 + 14'h4, 32'h04f83e7e, '1);
    apb(1'b1, C0 + 14'h8, 32'h1);
    pulse(32'h00010000);
    rdc(C0 + 14'h40, 32'h00800000, 32'h00f83e00);
    rdc(C0 + 14'h4, 32'h04f83e7e, '1);
    // Host-to-card with a partly armed field and no marker enable.
    apb(1'b1, C1 + 14'h4, 32'h00783e01);
    pulse(32'h0020000a);
    rdc(C1 + 14'h40, 32'h1, '1);
    rdc(C1 + 14'h48, 32'h1, '1);
    apb(1'b1, C1 + 14'h8, 32'h40);
    apb(1'b1, C1 + 14'hc, 32'h1);
    pulse(32'h2);
    rdc(C1 + 14'h40, 32'h40, '1);
    rdc(C1 + 14'h48, 32'h2, '1);
    // A reset after the host-to-card engine has gone idle returns the control and tally to zero.
    ARST_N <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    rdc(C1 + 14'h4, 32'h0, '1);
    rdc(C1 + 14'h48, 32'h0, '1);
    // An unmapped offset is refused.
    apb(1'b0, C0 + 14'h10, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    final_report();
  end
endmodule

// >>> inc/mmcs_pkg.sv
// Constants and types shared by the channel control and status register block.
//==============================================================================
// Behaviour
// - Run bit starts engine; clear stops after descriptor
// - Offset 0x08 sets control bits written one
// - Offset 0x0C clears control bits written one
// - Reading 0x44 returns and clears status 23:1
// - Status bit 0 shows engine busy
// - Count at 0x48 increments per finished descriptor
// - Count zeroed on rising edge of run
// - Descriptor error logged and stops when 0x1F
// - Read error logged and stops when 0x1F
// - Descriptor error cause bits four to zero
// - Read error: slave and decode; rest reserved
// - Setting run or writing one clears events
// - Bit 6 set when idle after run clears
// - Bit 5 set on bad descriptor length
// - Bit 4 set on invalid signature stop
// - Bit 3 flags misaligned source and destination
// - Bit 2 set on completion-marker descriptor finish
// - Bit 1 set on stop-flag descriptor finish
// - Control bit 26 writes count back on marker
// - Control bit 25 holds read address constant
// - Control bit 27 suppresses stream metadata writeback
// - Card-to-host at 0x1000, host-to-card at 0x1200
package mmcs_pkg;

  //============================================================================
  // Address map.
  //============================================================================
  // Channel bases in the byte address space.
  localparam logic [13:0] CARD_TO_HOST_BASE = 14'h1000;
  localparam logic [13:0] HOST_TO_CARD_BASE = 14'h1200;
  // Size of one channel window.
  localparam logic [13:0] CHAN_SPAN = 14'h0200;
  // Register offsets within a channel window.
  localparam logic [8:0] OFF_CONTROL = 9'h004;
  localparam logic [8:0] OFF_CONTROL_SET = 9'h008;
  localparam logic [8:0] OFF_CONTROL_CLR = 9'h00c;
  localparam logic [8:0] OFF_STATUS = 9'h040;
  localparam logic [8:0] OFF_STATUS_RC = 9'h044;
  localparam logic [8:0] OFF_COUNT = 9'h048;

  //============================================================================
  // Control fields.
  //============================================================================
  localparam int CTL_RUN = 0;
  localparam int CTL_IE_DESC_STOPPED = 1;
  localparam int CTL_IE_DESC_COMPLETED = 2;
  localparam int CTL_IE_ALIGN = 3;
  localparam int CTL_IE_MAGIC = 4;
  localparam int CTL_IE_LENGTH = 5;
  localparam int CTL_IE_IDLE = 6;
  localparam int CTL_NON_INC = 25;
  localparam int CTL_POLL_WB = 26;
  localparam int CTL_STREAM_WB_OFF = 27;
  // Bits that software may hold in the control register; the rest read zero.
  localparam logic [31:0] CTL_MASK = 32'h0ef83e7f;
  localparam logic [31:0] CTL_RESET = 32'h00000000;
  // Error-field enables must be all ones to arm logging.
  localparam logic [4:0] ERR_ARM = 5'h1f;

  //============================================================================
  // Status fields.
  //============================================================================
  localparam int ST_BUSY = 0;
  localparam int ST_DESC_STOPPED = 1;
  localparam int ST_DESC_COMPLETED = 2;
  localparam int ST_ALIGN = 3;
  localparam int ST_MAGIC = 4;
  localparam int ST_LENGTH = 5;
  localparam int ST_IDLE = 6;
  localparam int RD_ERR_LSB = 9;
  localparam int DESC_ERR_LSB = 19;
  // Sticky status bits 23:1 that exist; reserved bits read zero.
  localparam logic [31:0] ST_STICKY_MASK = 32'h00f8067e;
  // Read error causes use only bits 1:0; 4:2 are reserved.
  localparam logic [4:0] RD_ERR_VALID = 5'h03;
  localparam logic [31:0] ST_RESET = 32'h00000000;
  localparam logic [31:0] COUNT_RESET = 32'h00000000;

  // Engine state as seen by this block.
  typedef enum logic [1:0] {MMCS_IDLE, MMCS_RUN, MMCS_DRAIN} mmcs_eng_t;

endpackage
